// ==== shared/aiu_pkg.sv ====
// shared constants and types for the add and and instruction unit
package aiu_pkg;

	// ==================================================================
	// register map (byte addresses)
	localparam logic [7:0] REG_INSTR  = 8'h00;
	localparam logic [7:0] REG_ACC    = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_FADDR  = 8'h0C;
	localparam logic [7:0] REG_FDATA  = 8'h10;

	// ==================================================================
	// status field positions
	localparam int STAT_C    = 0;
	localparam int STAT_HC   = 1;
	localparam int STAT_Z    = 2;
	localparam int STAT_ILL  = 3;
	localparam int STAT_BUSY = 8;

	// ==================================================================
	// instruction word layout
	localparam int INSTR_W = 14;
	localparam int OPC_HI  = 13;
	localparam int OPC_LO  = 8;
	localparam int DEST_B  = 7;
	localparam int FA_HI   = 6;
	localparam int LIT_HI  = 7;

	localparam logic [5:0] OPC_AND_LIT = 6'h39;
	localparam logic [5:0] OPC_AND_REG = 6'h05;
	localparam logic [5:0] OPC_ADD_REG = 6'h07;
	localparam logic [4:0] OPC_ADD_LIT = 5'h1F;

	// ==================================================================
	// reset values
	localparam logic [7:0]  ACC_RST   = 8'h00;
	localparam logic [13:0] INSTR_RST = 14'h0000;
	localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

	typedef enum logic [2:0] {
		OP_NONE    = 3'h0,
		OP_ADD_LIT = 3'h1,
		OP_AND_LIT = 3'h2,
		OP_ADD_REG = 3'h3,
		OP_AND_REG = 3'h4
	} aiu_op_t;

	// gray along idle -> q1 -> q2 -> q3 -> q4; q4 -> idle flips two bits
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_Q1   = 3'b001,
		ST_Q2   = 3'b011,
		ST_Q3   = 3'b010,
		ST_Q4   = 3'b110
	} aiu_st_t;

	typedef struct packed {
		aiu_st_t     st;
		aiu_op_t     op;
		logic        dest;
		logic [6:0]  fa_ex;
		logic [7:0]  lit;
		logic [7:0]  res;
		logic        c_new;
		logic        hc_new;
		logic        c;
		logic        hc;
		logic        z;
		logic        ill;
		logic [7:0]  acc;
		logic [6:0]  fa_sw;
		logic [13:0] instr;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} aiu_state_t;

endpackage

// ==== sim/aiu_core_chk.sv ====
// apb-level checker for the add and and instruction unit
`timescale 1ns/1ps
module aiu_core_chk
	import aiu_pkg::*;
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	// ==============================================
	// helpers and properties
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic go;
	logic st_rd;
	assign go = pready && !pslverr && pwrite && paddr == REG_INSTR;
	assign st_rd = pready && !pwrite && paddr == REG_STATUS;
	chk_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("answer late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held");
	chk_ready_access: assert property (pready |-> $past(psel && penable))
		else $error("ready outside access");
	chk_rdata_idle: assert property (!pready |-> prdata == RD_ZERO)
		else $error("read data outside answer");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_unmapped_err: assert property (pready
		&& (paddr > REG_FDATA || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("unmapped accepted");
	// q1 to q4 span four cycles, so busy shows on any quick poll
	chk_busy_set: assert property (
		go ##[1:4] st_rd |-> prdata[STAT_BUSY])
		else $error("busy missing");
	chk_busy_clear: assert property (
		go ##1 (!go)[*5] ##[1:3] st_rd |-> !prdata[STAT_BUSY])
		else $error("busy stuck");
endmodule
bind aiu_core aiu_core_chk i_chk (.clk(clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr));

// ==== sim/test_add_and_instruction_unit.sv ====
// self-checking bench for the add and and instruction unit
`timescale 1ns/1ps
module test_add_and_instruction_unit
	import aiu_pkg::*;
;
	// ==============================================
	// stimulus and checks
	logic        clk = 0;
	logic        nrst = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic        er;
	int          fails = 0;
	int          total_checks = 0;
	always #4 clk = ~clk;
	aiu_core i_dut (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	task stop_test;
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("mismatch %0t seen %h want %h", $time, s, e);
		end
	endtask
	// idle cycle before each setup keeps one assignment per time step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		if (n >= 20) begin
			fails++;
			stop_test;
		end
		psel <= 0;
		penable <= 0;
	endtask
	task rdc(input logic [7:0] a, input logic [8:0] e);
		apb(0, a, 32'h0);
		chk(rd, {23'h0, e});
	endtask
	task poll;
		int n;
		n = 0;
		do begin
			apb(0, REG_STATUS, 32'h0);
			n++;
		end while (rd[STAT_BUSY] !== 1'b0 && n < 10);
		if (n >= 10) begin
			fails++;
			stop_test;
		end
	endtask
	task ex(input logic [13:0] i);
		apb(1, REG_INSTR, {18'h0, i});
		chk({31'h0, er}, 32'h0);
		poll;
	endtask
	task sc_lit;
		apb(1, REG_ACC, 32'h10);
		ex({OPC_ADD_LIT, 1'b0, 8'h15});
		rdc(REG_ACC, 9'h25);
		rdc(REG_STATUS, 9'h0);
		apb(1, REG_ACC, 32'hFF);
		ex({OPC_ADD_LIT, 1'b1, 8'h01});
		rdc(REG_ACC, 9'h0);
		rdc(REG_STATUS, 9'h7);
		ex({OPC_AND_LIT, 8'hFF});
		rdc(REG_STATUS, 9'h7);
		apb(1, REG_ACC, 32'hA3);
		ex({OPC_AND_LIT, 8'h5F});
		rdc(REG_ACC, 9'h3);
		rdc(REG_STATUS, 9'h3);
		apb(1, REG_STATUS, 32'h0);
		apb(1, REG_ACC, 32'h8);
		ex({OPC_ADD_LIT, 1'b0, 8'h08});
		rdc(REG_STATUS, 9'h2);
	endtask
	task sc_reg;
		apb(1, REG_FADDR, 32'h7F);
		apb(1, REG_FDATA, 32'hC2);
		apb(1, REG_ACC, 32'h17);
		ex({OPC_AND_REG, 1'b1, 7'h7F});
		rdc(REG_FDATA, 9'h02);
		rdc(REG_ACC, 9'h17);
		apb(1, REG_FDATA, 32'hC2);
		ex({OPC_ADD_REG, 1'b0, 7'h7F});
		rdc(REG_ACC, 9'hD9);
		rdc(REG_FDATA, 9'hC2);
		ex({OPC_ADD_REG, 1'b1, 7'h7F});
		rdc(REG_FDATA, 9'h9B);
		rdc(REG_ACC, 9'hD9);
		rdc(REG_STATUS, 9'h1);
		ex({OPC_AND_REG, 1'b0, 7'h7F});
		rdc(REG_ACC, 9'h99);
		rdc(REG_FDATA, 9'h9B);
		rdc(REG_STATUS, 9'h1);
	endtask
	task sc_busy;
		apb(1, REG_INSTR, {18'h0, OPC_AND_LIT, 8'h00});
		apb(1, REG_ACC, 32'h55);
		chk({31'h0, er}, 32'h1);
		poll;
		rdc(REG_ACC, 9'h0);
		rdc(REG_STATUS, 9'h005);
		// undecoded opcode: only the sticky illegal flag moves
		ex(14'h0000);
		rdc(REG_STATUS, 9'h00D);
		rdc(REG_ACC, 9'h0);
		apb(0, 8'h14, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1;
		rdc(REG_ACC, 9'h0);
		rdc(REG_STATUS, 9'h0);
		sc_lit;
		sc_reg;
		sc_busy;
		stop_test;
	end
endmodule

// ==== src/aiu_core.sv ====
// add and and instruction datapath with apb register access
// Operation
// - and-with-literal ands acc with the literal, sets only zero.
// - and-with-register ands acc with a file register, sets only zero.
// - register-form result with destination bit 0 goes to acc only.
// - dest bit 1 writes the result back to the file register only.
// - literal op: q1 decode, q2 read literal, q3 process, q4 write acc.
// - add-literal sums acc and literal into acc; sets c, digit carry, z.
// - add-register adds acc and file register into dest; sets 3 flags.
`timescale 1ns/1ps
module aiu_core
	import aiu_pkg::*;
#(
	parameter int FILE_DEPTH = 128
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	localparam int FA_W = 7;

	if (FILE_DEPTH < 1 || FILE_DEPTH > (1 << FA_W)) begin : g_chk
		$error("aiu_core: file depth must be 1 to 128");
	end

	// ==================================================================
	// decode
	function automatic aiu_op_t decode_op(input logic [13:0] iw);
		logic [5:0] opc;
		opc = iw[OPC_HI:OPC_LO];
		if (opc[5:1] == OPC_ADD_LIT) begin
			decode_op = OP_ADD_LIT;
		end else if (opc == OPC_AND_LIT) begin
			decode_op = OP_AND_LIT;
		end else if (opc == OPC_ADD_REG) begin
			decode_op = OP_ADD_REG;
		end else if (opc == OPC_AND_REG) begin
			decode_op = OP_AND_REG;
		end else begin
			decode_op = OP_NONE;
		end
	endfunction

	function automatic logic is_reg_form(input aiu_op_t op);
		is_reg_form = (op == OP_ADD_REG) || (op == OP_AND_REG);
	endfunction

	// ==================================================================
	// state
	aiu_state_t        s_q;
	aiu_state_t        s_d;
	logic              busy;
	logic              acc_ph;
	logic              setup_ph;
	logic              mem_we;
	logic [FA_W-1:0]   mem_waddr;
	logic [7:0]        mem_wdata;
	logic [FA_W-1:0]   mem_raddr;
	logic [7:0]        mem_rdata;
	logic [7:0]        opnd;
	logic [8:0]        sum9;
	logic [4:0]        sum5;

	assign busy     = (s_q.st != ST_IDLE);
	assign acc_ph   = psel && penable && !s_q.pready;
	assign setup_ph = psel && !penable;
	assign opnd     = is_reg_form(s_q.op) ? mem_rdata : s_q.lit;
	assign sum9     = {1'b0, s_q.acc} + {1'b0, opnd};
	assign sum5     = {1'b0, s_q.acc[3:0]} + {1'b0, opnd[3:0]};

	// ==================================================================
	// file memory port: execution owns it while busy
	always_comb begin
		mem_we    = 1'b0;
		mem_waddr = s_q.fa_sw;
		mem_wdata = pwdata[7:0];
		mem_raddr = busy ? s_q.fa_ex : s_q.fa_sw;
		if (s_q.st == ST_Q4 && is_reg_form(s_q.op) && s_q.dest) begin
			mem_we    = 1'b1;
			mem_waddr = s_q.fa_ex;
			mem_wdata = s_q.res;
		end else if (!busy && acc_ph && pwrite && paddr == REG_FDATA) begin
			mem_we = 1'b1;
		end
	end

	aiu_file_mem #(
		.DATA_W (8),
		.DEPTH  (FILE_DEPTH),
		.ADDR_W (FA_W)
	) u_mem (
		.clk   (clk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	// ==================================================================
	// next state
	always_comb begin
		s_d = s_q;
		// instruction sequencer
		case (s_q.st)
			ST_IDLE: begin
				s_d.st = ST_IDLE;
			end
			ST_Q1: begin
				s_d.op    = decode_op(s_q.instr);
				s_d.dest  = s_q.instr[DEST_B];
				s_d.fa_ex = s_q.instr[FA_HI:0];
				s_d.st    = ST_Q2;
			end
			ST_Q2: begin
				// register forms read the file here, data lands in q3
				s_d.lit = s_q.instr[LIT_HI:0];
				s_d.ill = s_q.ill || (s_q.op == OP_NONE);
				s_d.st  = ST_Q3;
			end
			ST_Q3: begin
				s_d.st = ST_Q4;
				case (s_q.op)
					OP_ADD_LIT, OP_ADD_REG: begin
						s_d.res    = sum9[7:0];
						s_d.c_new  = sum9[8];
						s_d.hc_new = sum5[4];
					end
					OP_AND_LIT, OP_AND_REG: begin
						s_d.res    = s_q.acc & opnd;
						s_d.c_new  = s_q.c;
						s_d.hc_new = s_q.hc;
					end
					default: begin
						s_d.res    = s_q.acc;
						s_d.c_new  = s_q.c;
						s_d.hc_new = s_q.hc;
					end
				endcase
			end
			ST_Q4: begin
				s_d.st = ST_IDLE;
				if (s_q.op != OP_NONE) begin
					// and forms carry both carries through unchanged
					s_d.c  = s_q.c_new;
					s_d.hc = s_q.hc_new;
					s_d.z  = (s_q.res == 8'h00);
					if (!(is_reg_form(s_q.op) && s_q.dest)) begin
						s_d.acc = s_q.res;
					end
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase

		// apb slave: answer is registered, one wait state per access
		s_d.pready  = acc_ph;
		s_d.pslverr = 1'b0;
		if (setup_ph || s_q.pready) begin
			s_d.prdata = RD_ZERO;
		end
		if (acc_ph) begin
			s_d.prdata = RD_ZERO;
			case (paddr)
				REG_INSTR: begin
					s_d.prdata[INSTR_W-1:0] = s_q.instr;
					if (pwrite) begin
						// refused while busy so an instruction is never torn
						if (busy) begin
							s_d.pslverr = 1'b1;
						end else begin
							s_d.instr = pwdata[INSTR_W-1:0];
							s_d.st    = ST_Q1;
						end
					end
				end
				REG_ACC: begin
					s_d.prdata[7:0] = s_q.acc;
					if (pwrite && busy) begin
						s_d.pslverr = 1'b1;
					end else if (pwrite) begin
						s_d.acc = pwdata[7:0];
					end
				end
				REG_STATUS: begin
					s_d.prdata[STAT_C]    = s_q.c;
					s_d.prdata[STAT_HC]   = s_q.hc;
					s_d.prdata[STAT_Z]    = s_q.z;
					s_d.prdata[STAT_ILL]  = s_q.ill;
					s_d.prdata[STAT_BUSY] = busy;
					if (pwrite && busy) begin
						s_d.pslverr = 1'b1;
					end else if (pwrite) begin
						s_d.c   = pwdata[STAT_C];
						s_d.hc  = pwdata[STAT_HC];
						s_d.z   = pwdata[STAT_Z];
						s_d.ill = pwdata[STAT_ILL];
					end
				end
				REG_FADDR: begin
					s_d.prdata[FA_W-1:0] = s_q.fa_sw;
					if (pwrite) begin
						s_d.fa_sw = pwdata[FA_W-1:0];
					end
				end
				REG_FDATA: begin
					// memory port belongs to the sequencer while busy
					if (busy) begin
						s_d.pslverr = 1'b1;
					end else if (!pwrite) begin
						s_d.prdata[7:0] = mem_rdata;
					end
				end
				default: begin
					s_d.pslverr = 1'b1;
				end
			endcase
		end
	end

	// ==================================================================
	// registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q         <= '0;
			s_q.st      <= ST_IDLE;
			s_q.op      <= OP_NONE;
			s_q.acc     <= ACC_RST;
			s_q.instr   <= INSTR_RST;
			s_q.prdata  <= RD_ZERO;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata  = s_q.prdata;
	assign pready  = s_q.pready;
	assign pslverr = s_q.pslverr;
endmodule

// ==== src/aiu_file_mem.sv ====
// file register memory with a registered read port
`timescale 1ns/1ps
module aiu_file_mem #(
	parameter int DATA_W = 8,
	parameter int DEPTH  = 128,
	parameter int ADDR_W = 7
) (
	input  wire logic              clk,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [DATA_W-1:0] rdata
);
	// ==================================================================
	// storage: no reset, contents are undefined until written
	logic [DATA_W-1:0] mem [DEPTH];

	if (DEPTH > (1 << ADDR_W) || DEPTH < 1) begin : g_chk
		$error("aiu_file_mem: depth does not fit address width");
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule
